// file: src/input_sync.sv
// Two-flop synchroniser for a group of unrelated level inputs.
// Each bit is independent; no bit group is treated as a coherent word.
`timescale 1ns/1ns
`default_nettype none
module input_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  input  wire logic             i_ce,
  // Levels
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_meta = i_ce ? i_async : meta;
    next_sync = i_ce ? meta : o_sync;
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= next_meta;
      o_sync <= next_sync;
    end
  end

endmodule
`default_nettype wire

// file: src/link_frame_shifter.sv
// Serial-clock domain shifters: one on each edge of the link clock.
// The host stops the link clock outside frames, so both words stand still
// once the load strobe is high.
`timescale 1ns/1ns
`default_nettype none
module link_frame_shifter #(
  parameter int FRAME_BITS = 21
) (
  // Link clock and reset
  input  wire logic                  i_serial_clock,
  input  wire logic                  i_nrst,
  // Link pins
  input  wire logic                  i_serial_data_line,
  input  wire logic                  i_load_strobe,
  // Shifted frames
  output var  logic [FRAME_BITS-1:0] o_rise_frame,
  output var  logic [FRAME_BITS-1:0] o_fall_frame
);

  logic [FRAME_BITS-1:0] next_rise_frame;
  logic [FRAME_BITS-1:0] next_fall_frame;

  // Most significant bit first; older bits fall off the top
  always_comb begin
    next_rise_frame = o_rise_frame;
    next_fall_frame = o_fall_frame;
    if (!i_load_strobe) begin
      next_rise_frame = {o_rise_frame[FRAME_BITS-2:0], i_serial_data_line};
      next_fall_frame = {o_fall_frame[FRAME_BITS-2:0], i_serial_data_line};
    end
  end

  always_ff @(posedge i_serial_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rise_frame <= '0;
    end else begin
      o_rise_frame <= next_rise_frame;
    end
  end

  always_ff @(negedge i_serial_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fall_frame <= '0;
    end else begin
      o_fall_frame <= next_fall_frame;
    end
  end

endmodule
`default_nettype wire

// file: src/motor_driver_serial_config_port.sv
// Three-wire write-only configuration port of a dual bridge driver.
// Assumes the host stops the serial clock while the load strobe is high
// and keeps the strobe high for several core clock periods.
// Node-select, sleep and supply inputs are levels that may change at any
// time; they are synchronised here before use.
// The serial clock runs on its own; only the shifters use it.
//
// How it works
// - Frames are 21 bits, MSB first, shifted while the load strobe is low.
// - Strobe rising edge copies the payload into the word chosen by bits 17..14.
// - Bits 20..18 address a device; a matching node code or broadcast address 0 accepts.
// - Node-select pins give node code 1 to 7; all low selects interface two.
// - Odd codes sample on falling clock edges, others on rising edges.
// - Node-select pins are watched continuously, no reset needed.
// - Word select decodes to watchdog, timing, shared, cycle and on-time words.
// - Serial input is ignored for 10 us after sleep rises.
// - Sleep low holds the port and its words in reset; bridges stand by.
// - Port leaves reset only with supply good and soft start finished.
// - Timing words: blank, off, fast decay, rectification bits; off MSB resets one.
// - Shared word: bridge B fields in 0..6, bridge A in 7..13, reset zero.
// - Cycle words keep a 13-bit cycle time, bit 13 ignored, reset zero.
// - Open active-high inputs read low and inactive.
// - On-time words keep a 13-bit on time and a phase bit, reset zero.
`timescale 1ns/1ns
`default_nettype none
module motor_driver_serial_config_port
  import serial_cfg_pkg::*;
(
  // Core clock and reset
  input  wire logic                                   i_clock,
  input  wire logic                                   i_nrst,
  input  wire logic                                   i_ce,
  // Serial link
  input  wire logic                                   i_serial_clock,
  input  wire logic                                   i_serial_data_line,
  input  wire logic                                   i_load_strobe,
  // Node select pins
  input  wire logic                                   i_node_select_pin0,
  input  wire logic                                   i_node_select_pin1,
  input  wire logic                                   i_node_select_pin2,
  // Power and mode levels
  input  wire logic                                   i_sleep,
  input  wire logic                                   i_power_on_threshold,
  input  wire logic                                   i_first_buck_regulator_done,
  // Configuration words
  output var  logic [serial_cfg_pkg::PAYLOAD_BITS-1:0] o_watchdog_setting_word,
  output var  logic [serial_cfg_pkg::PAYLOAD_BITS-1:0] o_bridge_a_timing_word,
  output var  logic [serial_cfg_pkg::PAYLOAD_BITS-1:0] o_bridge_b_timing_word,
  output var  logic [serial_cfg_pkg::PAYLOAD_BITS-1:0] o_shared_drive_word,
  output var  logic [serial_cfg_pkg::PAYLOAD_BITS-1:0] o_bridge_a_cycle_word,
  output var  logic [serial_cfg_pkg::PAYLOAD_BITS-1:0] o_bridge_b_cycle_word,
  output var  logic [serial_cfg_pkg::PAYLOAD_BITS-1:0] o_bridge_a_on_time_word,
  output var  logic [serial_cfg_pkg::PAYLOAD_BITS-1:0] o_bridge_b_on_time_word,
  // Status
  output var  logic [serial_cfg_pkg::NODE_BITS-1:0]    o_node_code,
  output var  logic                                   o_port_ready,
  output var  logic                                   o_bridges_standby,
  output var  logic                                   o_outputs_off,
  output var  logic                                   o_frame_accepted
);

  import serial_cfg_pkg::*;

  // ==========================================================
  // Helpers

  // Maps a word select code to a storage slot; bit 3 flags a legal code
  function automatic logic [SLOT_BITS:0] slot_of(input logic [SEL_BITS-1:0] sel);
    logic [SLOT_BITS:0] result;
    result = '0;
    case (sel)
      SEL_WATCHDOG:  result = {1'b1, SLOT_WATCHDOG};
      SEL_TIMING_A:  result = {1'b1, SLOT_TIMING_A};
      SEL_TIMING_B:  result = {1'b1, SLOT_TIMING_B};
      SEL_SHARED:    result = {1'b1, SLOT_SHARED};
      SEL_CYCLE_A:   result = {1'b1, SLOT_CYCLE_A};
      SEL_CYCLE_B:   result = {1'b1, SLOT_CYCLE_B};
      SEL_ON_TIME_A: result = {1'b1, SLOT_ON_TIME_A};
      SEL_ON_TIME_B: result = {1'b1, SLOT_ON_TIME_B};
      // Select 0011 is reserved for factory test and never loaded
      SEL_RESERVED:  result = '0;
      default:       result = '0;
    endcase
    return result;
  endfunction

  // Address match, broadcast included
  // Node code 0 still answers broadcast frames
  function automatic logic addressed(input logic [NODE_BITS-1:0] addr,
                                     input logic [NODE_BITS-1:0] node);
    return (addr == BROADCAST_ADDR) || (addr == node);
  endfunction

  // ==========================================================
  // Link domain

  // Both edges are shifted; the node code picks one word at load time.
  // The core reads the words only after the synced strobe has risen,
  // while the host holds the serial clock still, so they are static.

  logic [FRAME_BITS-1:0] rise_frame;
  logic [FRAME_BITS-1:0] fall_frame;

  link_frame_shifter #(
    .FRAME_BITS (FRAME_BITS)
  ) u_shifter (
    .i_serial_clock     (i_serial_clock),
    .i_nrst             (i_nrst),
    .i_serial_data_line (i_serial_data_line),
    .i_load_strobe      (i_load_strobe),
    .o_rise_frame       (rise_frame),
    .o_fall_frame       (fall_frame)
  );

  // ==========================================================
  // Pin synchronisers

  localparam int SYNC_WIDTH = 7;

  logic [SYNC_WIDTH-1:0] pins_async;
  logic [SYNC_WIDTH-1:0] pins_sync;
  logic                  strobe_sync;
  logic                  sleep_sync;
  logic                  supply_good;
  logic                  soft_start_done;
  logic [NODE_BITS-1:0]  node_sync;

  // Open active-high pins are pulled low at the pad and read inactive
  assign pins_async = {i_load_strobe, i_sleep, i_power_on_threshold,
                       i_first_buck_regulator_done,
                       i_node_select_pin2, i_node_select_pin1,
                       i_node_select_pin0};

  input_sync #(
    .WIDTH (SYNC_WIDTH)
  ) u_sync (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_ce    (i_ce),
    .i_async (pins_async),
    .o_sync  (pins_sync)
  );

  assign strobe_sync     = pins_sync[6];
  assign sleep_sync      = pins_sync[5];
  assign supply_good     = pins_sync[4];
  assign soft_start_done = pins_sync[3];
  // New pin levels take effect two cycles later, with no reset
  assign node_sync       = pins_sync[2:0];

  // ==========================================================
  // Node code and edge choice

  logic                  port_alive;
  logic                  port_enable;
  logic                  sample_falling;
  logic [FRAME_BITS-1:0] frame;
  logic [NODE_BITS-1:0]  frame_addr;
  logic [SEL_BITS-1:0]   frame_sel;
  logic [SLOT_BITS:0]    frame_slot;

  assign port_alive     = supply_good & soft_start_done;
  assign port_enable    = port_alive & sleep_sync;
  // Odd node codes take the falling-edge word
  assign sample_falling = node_sync[0];
  assign frame          = sample_falling ? fall_frame : rise_frame;
  // Fields are cut from the chosen word
  assign frame_addr     = frame[ADDR_MSB:ADDR_LSB];
  assign frame_sel      = frame[SEL_MSB:SEL_LSB];
  assign frame_slot     = slot_of(frame_sel);

  // ==========================================================
  // Port state and hold-off

  port_state_e              state;
  port_state_e              next_state;
  logic [HOLDOFF_WIDTH-1:0] holdoff_count;
  logic [HOLDOFF_WIDTH-1:0] next_holdoff_count;

  localparam logic [HOLDOFF_WIDTH-1:0] HOLDOFF_LAST = HOLDOFF_WIDTH'(HOLDOFF_CYCLES - 1);

  // Any drop of sleep or supply restarts the hold-off, so even a short
  // sleep pulse costs the full interval before frames count again.

  always_comb begin
    next_state         = state;
    next_holdoff_count = holdoff_count;
    case (state)
      PORT_OFF: begin
        if (port_enable) begin
          next_state         = PORT_HOLDOFF;
          next_holdoff_count = '0;
        end
      end
      PORT_HOLDOFF: begin
        if (!port_enable) begin
          next_state = PORT_OFF;
        end else if (holdoff_count == HOLDOFF_LAST) begin
          next_state = PORT_READY;
        end else begin
          next_holdoff_count = holdoff_count + 1'b1;
        end
      end
      PORT_READY: begin
        if (!port_enable) begin
          next_state = PORT_OFF;
        end
      end
      default: begin
        next_state = PORT_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state         <= PORT_OFF;
      holdoff_count <= '0;
    end else if (i_ce) begin
      state         <= next_state;
      holdoff_count <= next_holdoff_count;
    end
  end

  // ==========================================================
  // Frame load

  logic strobe_prev;
  logic next_strobe_prev;
  logic strobe_rise;
  logic load_frame;
  logic next_frame_accepted;

  // The strobe edge is found two core flops after the pin
  assign strobe_rise = strobe_sync & ~strobe_prev;

  // Reserved select 0011 has no slot and is dropped
  // A drop of sleep or supply refuses a load in the same cycle
  assign load_frame = (state == PORT_READY) && port_enable && strobe_rise
                      && addressed(frame_addr, node_sync)
                      && frame_slot[SLOT_BITS];

  always_comb begin
    next_strobe_prev    = strobe_sync;
    next_frame_accepted = load_frame;
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      strobe_prev      <= 1'b0;
      o_frame_accepted <= 1'b0;
    end else if (i_ce) begin
      strobe_prev      <= next_strobe_prev;
      o_frame_accepted <= next_frame_accepted;
    end
  end

  // ==========================================================
  // Configuration words

  logic [PAYLOAD_BITS-1:0] cfg      [SLOT_COUNT];
  logic [PAYLOAD_BITS-1:0] next_cfg [SLOT_COUNT];
  logic [PAYLOAD_BITS-1:0] payload;

  assign payload = frame[PAYLOAD_BITS-1:0];

  always_comb begin
    for (int i = 0; i < SLOT_COUNT; i++) begin
      next_cfg[i] = cfg[i];
    end
    // Sleep or supply loss wins over a load in the same cycle
    if (!port_enable) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        next_cfg[i] = SLOT_RESET[i];
      end
    end else if (load_frame) begin
      // Unused payload bits are masked to zero
      next_cfg[frame_slot[SLOT_BITS-1:0]] =
        payload & SLOT_MASK[frame_slot[SLOT_BITS-1:0]];
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        cfg[i] <= SLOT_RESET[i];
      end
    end else if (i_ce) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        cfg[i] <= next_cfg[i];
      end
    end
  end

  // ==========================================================
  // Outputs

  // Words change on core clock edges only, never on a serial clock edge
  assign o_watchdog_setting_word = cfg[SLOT_WATCHDOG];
  assign o_bridge_a_timing_word  = cfg[SLOT_TIMING_A];
  assign o_bridge_b_timing_word  = cfg[SLOT_TIMING_B];
  assign o_shared_drive_word     = cfg[SLOT_SHARED];
  assign o_bridge_a_cycle_word   = cfg[SLOT_CYCLE_A];
  assign o_bridge_b_cycle_word   = cfg[SLOT_CYCLE_B];
  assign o_bridge_a_on_time_word = cfg[SLOT_ON_TIME_A];
  assign o_bridge_b_on_time_word = cfg[SLOT_ON_TIME_B];

  // Node code 0 means the second interface, which is not built here
  assign o_node_code       = node_sync;

  // ==========================================================
  // Status registers

  logic next_port_ready;
  logic next_bridges_standby;
  logic next_outputs_off;

  // Ready follows next_state, so it changes in the same cycle as state
  // Standby follows sleep alone; supply loss shows on outputs_off
  always_comb begin
    next_port_ready      = (next_state == PORT_READY);
    next_bridges_standby = ~sleep_sync;
    next_outputs_off     = ~port_alive;
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_port_ready      <= 1'b0;
      o_bridges_standby <= 1'b1;
      o_outputs_off     <= 1'b1;
    end else if (i_ce) begin
      o_port_ready      <= next_port_ready;
      o_bridges_standby <= next_bridges_standby;
      o_outputs_off     <= next_outputs_off;
    end
  end

endmodule
`default_nettype wire

// file: src/serial_cfg_pkg.sv
// Constants and types of the three-wire configuration port.
// Assumes a 250 MHz core clock; the link clock is the host's serial clock.
package serial_cfg_pkg;

  // ==========================================================
  // Frame layout
  localparam int FRAME_BITS   = 21;
  localparam int PAYLOAD_BITS = 14;
  localparam int NODE_BITS    = 3;
  localparam int SEL_BITS     = 4;
  localparam int ADDR_MSB     = 20;
  localparam int ADDR_LSB     = 18;
  localparam int SEL_MSB      = 17;
  localparam int SEL_LSB      = 14;
  localparam int SLOT_COUNT   = 8;
  localparam int SLOT_BITS    = 3;

  localparam logic [NODE_BITS-1:0] BROADCAST_ADDR = 3'h0;

  // ==========================================================
  // Word select codes
  localparam logic [SEL_BITS-1:0] SEL_WATCHDOG  = 4'hf;
  localparam logic [SEL_BITS-1:0] SEL_TIMING_A  = 4'h0;
  localparam logic [SEL_BITS-1:0] SEL_TIMING_B  = 4'h1;
  localparam logic [SEL_BITS-1:0] SEL_SHARED    = 4'h2;
  localparam logic [SEL_BITS-1:0] SEL_RESERVED  = 4'h3;
  localparam logic [SEL_BITS-1:0] SEL_CYCLE_A   = 4'h4;
  localparam logic [SEL_BITS-1:0] SEL_CYCLE_B   = 4'h5;
  localparam logic [SEL_BITS-1:0] SEL_ON_TIME_A = 4'h6;
  localparam logic [SEL_BITS-1:0] SEL_ON_TIME_B = 4'h7;

  // ==========================================================
  // Storage slots
  localparam logic [SLOT_BITS-1:0] SLOT_WATCHDOG  = 3'h0;
  localparam logic [SLOT_BITS-1:0] SLOT_TIMING_A  = 3'h1;
  localparam logic [SLOT_BITS-1:0] SLOT_TIMING_B  = 3'h2;
  localparam logic [SLOT_BITS-1:0] SLOT_SHARED    = 3'h3;
  localparam logic [SLOT_BITS-1:0] SLOT_CYCLE_A   = 3'h4;
  localparam logic [SLOT_BITS-1:0] SLOT_CYCLE_B   = 3'h5;
  localparam logic [SLOT_BITS-1:0] SLOT_ON_TIME_A = 3'h6;
  localparam logic [SLOT_BITS-1:0] SLOT_ON_TIME_B = 3'h7;

  // ==========================================================
  // Kept bits and reset values per slot
  localparam logic [PAYLOAD_BITS-1:0] WATCHDOG_MASK  = 14'h0003;
  localparam logic [PAYLOAD_BITS-1:0] TIMING_MASK    = 14'h1fff;
  localparam logic [PAYLOAD_BITS-1:0] SHARED_MASK    = 14'h3fff;
  localparam logic [PAYLOAD_BITS-1:0] CYCLE_MASK     = 14'h1fff;
  localparam logic [PAYLOAD_BITS-1:0] ON_TIME_MASK   = 14'h3fff;
  localparam logic [PAYLOAD_BITS-1:0] WATCHDOG_RESET = 14'h0000;
  localparam logic [PAYLOAD_BITS-1:0] TIMING_RESET   = 14'h0040;
  localparam logic [PAYLOAD_BITS-1:0] SHARED_RESET   = 14'h0000;
  localparam logic [PAYLOAD_BITS-1:0] CYCLE_RESET    = 14'h0000;
  localparam logic [PAYLOAD_BITS-1:0] ON_TIME_RESET  = 14'h0000;

  localparam logic [PAYLOAD_BITS-1:0] SLOT_MASK [SLOT_COUNT] = '{
    WATCHDOG_MASK, TIMING_MASK, TIMING_MASK, SHARED_MASK,
    CYCLE_MASK, CYCLE_MASK, ON_TIME_MASK, ON_TIME_MASK};
  localparam logic [PAYLOAD_BITS-1:0] SLOT_RESET [SLOT_COUNT] = '{
    WATCHDOG_RESET, TIMING_RESET, TIMING_RESET, SHARED_RESET,
    CYCLE_RESET, CYCLE_RESET, ON_TIME_RESET, ON_TIME_RESET};

  // ==========================================================
  // Timing
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int HOLDOFF_NS      = 10000;
  localparam int HOLDOFF_CYCLES  = (HOLDOFF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int HOLDOFF_WIDTH   = 12;

  // ==========================================================
  // Port state
  typedef enum logic [1:0] {
    PORT_OFF,
    PORT_HOLDOFF,
    PORT_READY
  } port_state_e;

endpackage

// file: testbench/motor_driver_serial_config_port_chk.sv
// Concurrent checks on the configuration port's top-level pins.
// Assumes a single core clock domain; bound to every instance of the port.
`timescale 1ns/1ns
`default_nettype none
module motor_driver_serial_config_port_chk (
  // Clock and levels
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic        i_load_strobe,
  input wire logic        i_node_select_pin0,
  input wire logic        i_node_select_pin1,
  input wire logic        i_node_select_pin2,
  input wire logic        i_sleep,
  input wire logic        i_power_on_threshold,
  input wire logic        i_first_buck_regulator_done,
  // Outputs
  input wire logic [13:0] o_watchdog_setting_word,
  input wire logic [13:0] o_bridge_a_timing_word,
  input wire logic [13:0] o_shared_drive_word,
  input wire logic [13:0] o_bridge_a_cycle_word,
  input wire logic [2:0]  o_node_code,
  input wire logic        o_port_ready,
  input wire logic        o_bridges_standby,
  input wire logic        o_outputs_off,
  input wire logic        o_frame_accepted
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  // ==========================================================
  // Cycles with all power conditions good
  logic [11:0] good_cnt;
  logic [11:0] next_good_cnt;
  logic        all_good;
  logic [2:0]  pins;
  assign all_good = i_sleep && i_power_on_threshold && i_first_buck_regulator_done;
  assign pins     = {i_node_select_pin2, i_node_select_pin1, i_node_select_pin0};
  always_comb begin
    next_good_cnt = good_cnt;
    if (!all_good) next_good_cnt = 12'h000;
    else if (good_cnt != 12'hfff) next_good_cnt = good_cnt + 12'h001;
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) good_cnt <= 12'h000;
    else good_cnt <= next_good_cnt;
  end

  // ==========================================================
  // Assertions
  a_accept_after_strobe: assert property (o_frame_accepted |->
    $past(i_load_strobe, 2) && $past(o_port_ready))
    else $error("accept without strobe or ready");
  a_accept_one_cycle: assert property (o_frame_accepted |=> !o_frame_accepted)
    else $error("accept pulse too long");
  a_holdoff_early: assert property ($rose(o_port_ready) |-> good_cnt >= 12'h9c4)
    else $error("ready before hold-off ended");
  a_holdoff_late: assert property (good_cnt == 12'h9d8 |-> o_port_ready)
    else $error("ready late");
  a_sleep_standby: assert property (!i_sleep [*4] |->
    o_bridges_standby && !o_port_ready && !o_frame_accepted)
    else $error("sleep not honoured");
  a_sleep_clears: assert property (!i_sleep [*5] |-> o_bridge_a_timing_word == 14'h0040
    && o_shared_drive_word == 14'h0000 && o_bridge_a_cycle_word == 14'h0000)
    else $error("words not cleared in sleep");
  a_supply_off: assert property (!i_power_on_threshold [*4] |->
    o_outputs_off && !o_port_ready)
    else $error("outputs not off");
  a_node_follow: assert property ($stable(pins) [*3] |-> o_node_code == pins)
    else $error("node code stale");
  a_unused_bits: assert property (o_watchdog_setting_word[13:2] == 12'h000
    && !o_bridge_a_timing_word[13] && !o_bridge_a_cycle_word[13])
    else $error("unused bit set");
  c_accept: cover property (o_frame_accepted);
  c_ready: cover property ($rose(o_port_ready));
  c_standby: cover property ($rose(o_bridges_standby));
endmodule

bind motor_driver_serial_config_port motor_driver_serial_config_port_chk chk_u (
  .i_clock, .i_nrst, .i_load_strobe, .i_node_select_pin0, .i_node_select_pin1,
  .i_node_select_pin2, .i_sleep, .i_power_on_threshold, .i_first_buck_regulator_done,
  .o_watchdog_setting_word, .o_bridge_a_timing_word, .o_shared_drive_word,
  .o_bridge_a_cycle_word, .o_node_code, .o_port_ready, .o_bridges_standby,
  .o_outputs_off, .o_frame_accepted);
`default_nettype wire

// file: testbench/motor_driver_serial_config_port_test.sv
// Self-checking bench of the configuration port against a word model.
// Assumes serial_host_model drives the link pins.
`timescale 1ns/1ns
`default_nettype none
module motor_driver_serial_config_port_test;
  import serial_cfg_pkg::*;
  logic i_clock, i_nrst, i_sleep, i_power_on_threshold, i_first_buck_regulator_done;
  logic [2:0] pins;
  wire logic sck, sdat, sstb;
  logic [7:0][13:0] got;
  logic [13:0] expw [8];
  logic [2:0] node_code;
  logic ready, standby, off, acc;
  logic [3:0] sels [10] = '{4'hf, 4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'he};
  int bad_count, checks, node, k, d, adr;
  logic [31:0] fr, fr2;

  serial_host_model host_u (.o_serial_clock(sck), .o_serial_data_line(sdat),
    .o_load_strobe(sstb));
  motor_driver_serial_config_port dut_u (
    .i_clock, .i_nrst, .i_ce(1'b1), .i_serial_clock(sck), .i_serial_data_line(sdat),
    .i_load_strobe(sstb), .i_node_select_pin0(pins[0]), .i_node_select_pin1(pins[1]),
    .i_node_select_pin2(pins[2]), .i_sleep, .i_power_on_threshold,
    .i_first_buck_regulator_done,
    .o_watchdog_setting_word(got[0]), .o_bridge_a_timing_word(got[1]),
    .o_bridge_b_timing_word(got[2]), .o_shared_drive_word(got[3]),
    .o_bridge_a_cycle_word(got[4]), .o_bridge_b_cycle_word(got[5]),
    .o_bridge_a_on_time_word(got[6]), .o_bridge_b_on_time_word(got[7]),
    .o_node_code(node_code), .o_port_ready(ready), .o_bridges_standby(standby),
    .o_outputs_off(off), .o_frame_accepted(acc));

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      bad_count++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  function automatic int slot_of(input logic [3:0] s);
    case (s)
      4'hf: return 0;
      4'h0, 4'h1, 4'h2: return int'(s) + 1;
      4'h4, 4'h5, 4'h6, 4'h7: return int'(s);
      default: return -1;
    endcase
  endfunction
  task automatic words();
    for (int i = 0; i < 8; i++) check(got[i], expw[i]);
  endtask
  task automatic set_node(input int v);
    pins = v[2:0];
    node = v;
    cyc(4);
    check(node_code, v);
  endtask
  task automatic wait_ready();
    for (k = 0; k < 3000 && ready !== 1'b1; k++) cyc(1);
    if (k == 3000) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic frame(input logic [31:0] rf, input logic [31:0] ff, input int n);
    logic [20:0] f;
    logic        seen;
    int          s;
    f = node[0] ? ff[20:0] : rf[20:0];
    s = slot_of(f[17:14]);
    seen = 1'b0;
    // Watch while sending: the accept pulse lasts one cycle
    fork
      host_u.send(rf, ff, n);
      repeat (n * 12 + 12) begin
        cyc(1);
        if (acc === 1'b1) seen = 1'b1;
      end
    join
    if (ready === 1'b1 && s >= 0 && (f[20:18] == 3'h0 || f[20:18] == node[2:0])) begin
      expw[s] = f[13:0] & SLOT_MASK[s];
      check(seen, 1);
    end else check(seen, 0);
    words();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    i_nrst = 1'b0;
    i_sleep = 1'b0;
    i_power_on_threshold = 1'b0;
    i_first_buck_regulator_done = 1'b0;
    pins = 3'h1;
    node = 1;
    bad_count = 0;
    checks = 0;
    void'($urandom(27638));
    for (int i = 0; i < 8; i++) expw[i] = SLOT_RESET[i];
    cyc(20);
    i_nrst = 1'b1;
    cyc(3);
    words();
    check({ready, standby, off}, 3'b011);
    i_power_on_threshold = 1'b1;
    i_first_buck_regulator_done = 1'b1;
    i_sleep = 1'b1;
    wait_ready();
    check(k >= 2500 && k <= 2512, 1);
    foreach (sels[j]) for (int a = 0; a < 3; a++) begin
      set_node(1 + $urandom_range(6));
      d = $urandom;
      adr = (a == 0) ? node : (a == 1) ? 0 : (node % 7) + 1;
      fr = {11'h000, adr[2:0], sels[j], d[13:0]};
      frame(fr, fr, 21);
    end
    foreach (sels[j]) if (j < 3) begin
      set_node(j == 0 ? 0 : j + 1);
      d = $urandom;
      fr = {11'h000, 3'h0, 4'h2, d[13:0]};
      fr2 = {11'h000, 3'h0, 4'h2, ~d[13:0]};
      frame(fr, fr2, 21);
    end
    d = $urandom;
    frame({d[10:0], 3'h0, 4'h6, d[26:13]}, {d[10:0], 3'h0, 4'h6, d[26:13]}, 25);
    i_sleep = 1'b0;
    cyc(6);
    for (int i = 0; i < 8; i++) expw[i] = SLOT_RESET[i];
    words();
    check({standby, ready}, 2'b10);
    i_sleep = 1'b1;
    fr = {11'h000, 3'h0, 4'h2, 14'h1555};
    frame(fr, fr, 21);
    wait_ready();
    frame(fr, fr, 21);
    i_power_on_threshold = 1'b0;
    cyc(6);
    for (int i = 0; i < 8; i++) expw[i] = SLOT_RESET[i];
    words();
    check({off, ready}, 2'b10);
    i_power_on_threshold = 1'b1;
    wait_ready();
    print_verdict();
  end
endmodule
`default_nettype wire

// file: testbench/serial_host_model.sv
// Host side of the three-wire configuration link.
// Assumes the bench calls send() hierarchically; link clock idles low.
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
  // Link pins
  output var logic o_serial_clock,
  output var logic o_serial_data_line,
  output var logic o_load_strobe
);
  initial begin
    o_serial_clock     = 1'b0;
    o_serial_data_line = 1'b0;
    o_load_strobe      = 1'b1;
  end

  // ==========================================================
  // Frame sender, 48 ns link period
  // Each bit: rf value across the rising edge, ff value across the falling one
  task automatic send(input logic [31:0] rf, input logic [31:0] ff, input int n);
    o_load_strobe = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_data_line = rf[i];
      #12 o_serial_clock = 1'b1;
      #12 o_serial_data_line = ff[i];
      #12 o_serial_clock = 1'b0;
      #12;
    end
    o_load_strobe = 1'b1;
    #24 o_serial_data_line = ~o_serial_data_line;
  endtask
endmodule
`default_nettype wire
